// ==== hdl/cbsc_clkgen.sv ====
// Two-phase clock divider and status strobe generator
`timescale 1ns/100ps
`default_nettype none
module cbsc_clkgen (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic sync_in,
	output logic phase1_out,
	output logic phase2_out,
	output logic tick_out,
	output logic status_latch_strobe_out
);
	import cbsc_pkg::*;
	logic [3:0] div;
	wire last_w = (div == CBSC_DIV_LAST);
	// Divide by nine, one state per wrap
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			div <= 4'h0;
		end else begin
			div <= last_w ? 4'h0 : div + 4'h1;
		end
	end
	// Asymmetrical phases: short phase1, longer phase2
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			phase1_out <= 1'b0;
			phase2_out <= 1'b0;
			status_latch_strobe_out <= 1'b0;
		end else begin
			phase1_out <= last_w || div < CBSC_PH1_END - 4'h1;
			phase2_out <= div >= CBSC_PH1_END && div < 4'h7;
			// Strobe only in the last ninth of the first state
			status_latch_strobe_out <= sync_in && div == CBSC_STB_TICK - 4'h1;
		end
	end
	assign tick_out = last_w;
endmodule
`default_nettype wire

// ==== hdl/cbsc_core.sv ====
// Processor bus core: machine cycle sequencer and system controller
// Behaviour
// - Hold request is honoured only after the current machine cycle ends.
// - Hold acknowledge output shows hold state and buses released.
// - Interrupt request fetches a vector from the bus, then branches there.
// - Sync output marks every machine cycle start; combined into strobe.
// - Reset clears program counter so execution starts at zero.
// - Write strobe marks stable write data on the data bus.
// - Read accept output shows the bus is ready for read data.
// - Readable devices on bidirectional bus; write-only on output bus.
// - Status byte placed on data bus at each machine cycle start.
// - Latched status plus three controls give acknowledge and strobes.
// - During hold all controller outputs float.
// - Crystal divided by nine gives the system clock period.
// - Asymmetrical two phases; phase two also clocks serial logic.
// - Status strobe only in final ninth of first state.
// - Ready synchronised to cycles; low means wait state.
// - Reset is given out in both polarities.
// - Frame interrupt raised at fifty or sixty hertz.
`timescale 1ns/100ps
`default_nettype none
module cbsc_core #(
	parameter int FRAME_CYC_50 = cbsc_pkg::CBSC_FRAME_CYC_50,
	parameter int FRAME_CYC_60 = cbsc_pkg::CBSC_FRAME_CYC_60
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// Processor side request
	input wire logic req_valid_in,
	input wire logic req_write_in,
	input wire logic req_io_in,
	input wire logic [15:0] req_addr_in,
	input wire logic [7:0] req_wdata_in,
	output logic req_done_out,
	output logic [7:0] rdata_out,
	// Bus control inputs
	input wire logic hold_request_in,
	input wire logic ready_in,
	input wire logic irq_request_line_in,
	input wire logic rate_50hz_in,
	// Bidirectional data bus
	input wire logic [7:0] bidir_data_bus_in,
	output logic [7:0] bidir_data_bus_out,
	output logic bidir_data_bus_oe_n_out,
	// Write-only output bus
	output logic [7:0] out_data_bus_out,
	// Address bus
	output logic [15:0] addr_out,
	output logic addr_oe_n_out,
	// Control strobes, active low, with shared float enable
	output logic mem_read_n_out,
	output logic mem_write_n_out,
	output logic io_read_n_out,
	output logic io_write_n_out,
	output logic irq_acknowledge_n_out,
	output logic ctrl_oe_n_out,
	// Processor status and clocks
	output logic bus_hold_ack_out,
	output logic sync_out,
	output logic read_data_accept_out,
	output logic write_strobe_n_out,
	output logic phase1_out,
	output logic phase2_out,
	output logic serial_clk_out,
	output logic status_latch_strobe_out,
	output logic frame_irq_out,
	output logic [15:0] pc_out,
	output logic reset_out,
	output logic reset_n_out
);
	import cbsc_pkg::*;
	cbsc_state_t state;
	cbsc_state_t next_state;
	logic tick;
	logic ready_sync;
	logic irq_pend;
	logic vector_cycle;
	logic [7:0] status;
	logic [7:0] status_latch;
	logic [15:0] cyc_addr;
	logic [7:0] cyc_wdata;
	logic [15:0] pc;
	logic stb;
	logic cyc_write;
	logic cyc_io;
	logic [15:0] next_pc;

	// Clock generation and strobe
	// Strobe comes back registered, one clock, at the end of the state
	cbsc_clkgen u_clkgen (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.sync_in(sync_out),
		.phase1_out(phase1_out),
		.phase2_out(phase2_out),
		.tick_out(tick),
		.status_latch_strobe_out(stb)
	);

	// Frame counts are parameters so a bench can shorten the frame
	cbsc_frame_irq #(
		.FRAME_CYC_50(FRAME_CYC_50),
		.FRAME_CYC_60(FRAME_CYC_60)
	) u_frame (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.rate_50hz_in(rate_50hz_in),
		.frame_irq_out(frame_irq_out)
	);

	// Serial logic runs from a buffered copy of phase two
	assign serial_clk_out = phase2_out;
	assign status_latch_strobe_out = stb;
	// Both reset polarities given out
	assign reset_out = rst_in;
	assign reset_n_out = ~rst_in;
	assign pc_out = pc;

	// A pending interrupt takes the next cycle ahead of a request
	wire start_vec_w = irq_pend && !vector_cycle;
	wire wr_cyc_w = cyc_write && !vector_cycle;
	wire rd_space_w = !cyc_write && !vector_cycle;

	// Status byte of the cycle in progress, built from what was captured
	// at its start; the request inputs may already have moved on, so
	// they must not feed the byte that the strobe latches later
	always_comb begin
		status = 8'h00;
		status[CBSC_ST_IRQ_ACKNOWLEDGE] = vector_cycle;
		status[CBSC_ST_WO_N] = !wr_cyc_w;
		status[CBSC_ST_OUT] = cyc_io && wr_cyc_w;
		status[CBSC_ST_INP] = cyc_io && rd_space_w;
		status[CBSC_ST_MEMR] = !cyc_io && rd_space_w;
		status[CBSC_ST_M1] = vector_cycle;
	end

	// Cycle sequencer; hold taken only at a cycle boundary
	wire at_boundary_w = (state == CBSC_T3) || (state == CBSC_T1 && !sync_out);
	wire take_hold_w = hold_request_in && at_boundary_w;
	wire start_w = (req_valid_in || irq_pend) && state == CBSC_T1;
	// Cycle begins at an idle first state; ends on the way back to it
	wire cyc_begin_w = start_w && !sync_out && !hold_request_in;
	wire cyc_end_w = next_state == CBSC_T1 && state != CBSC_T1;
	always_comb begin
		next_state = state;
		case (state)
			CBSC_T1: begin
				// Once sync is up the cycle has begun and must run out
				if (take_hold_w) begin
					next_state = CBSC_HOLD;
				end else if (sync_out) begin
					next_state = CBSC_T2;
				end
			end
			// Wait while ready is low
			CBSC_T2: next_state = ready_sync ? CBSC_T3 : CBSC_T2;
			CBSC_T3: next_state = take_hold_w ? CBSC_HOLD : CBSC_T1;
			CBSC_HOLD: next_state = hold_request_in ? CBSC_HOLD : CBSC_T1;
			default: next_state = CBSC_T1;
		endcase
	end

	// State advances once per processor state time
	// Ready is looked at once per state, so a glitch cannot split one
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			state <= CBSC_T1;
			ready_sync <= 1'b1;
		end else if (tick) begin
			state <= next_state;
			ready_sync <= ready_in;
		end
	end

	// Sync raised for the first state of each cycle
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			sync_out <= 1'b0;
		end else if (tick) begin
			sync_out <= cyc_end_w ? 1'b0 : cyc_begin_w;
		end
	end

	// Capture cycle parameters and place status on the bus
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			cyc_addr <= 16'h0000;
			cyc_wdata <= 8'h00;
			cyc_write <= 1'b0;
			cyc_io <= 1'b0;
			vector_cycle <= 1'b0;
		end else if (tick && cyc_begin_w) begin
			// Requests are sampled once; the rest of the cycle uses copies
			cyc_addr <= start_vec_w ? pc : req_addr_in;
			cyc_wdata <= req_wdata_in;
			cyc_write <= req_write_in;
			cyc_io <= req_io_in;
			vector_cycle <= start_vec_w;
		end else if (tick && state == CBSC_T3) begin
			vector_cycle <= 1'b0;
		end
	end

	// Status latched on the strobe
	// Resets to a plain read so no write strobe shows before a cycle
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			status_latch <= 8'h02;
		end else if (stb) begin
			status_latch <= status;
		end
	end

	// Interrupt pending; a new request wins over the acknowledge clear
	// The line may be a one-clock pulse; pending keeps it until served
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			irq_pend <= 1'b0;
		end else if (irq_request_line_in) begin
			irq_pend <= 1'b1;
		end else if (tick && state == CBSC_T3 && vector_cycle) begin
			irq_pend <= 1'b0;
		end
	end

	// Next program counter: vector byte at the end of an acknowledge
	// cycle, otherwise one step per finished cycle; the vector gives only
	// the low byte, so handlers must sit in the first page
	wire cyc_done_w = tick && state == CBSC_T3;
	always_comb begin
		next_pc = pc;
		if (cyc_done_w && vector_cycle) begin
			next_pc = {8'h00, bidir_data_bus_in};
		end else if (cyc_done_w) begin
			next_pc = pc + 16'h0001;
		end
	end

	// Program counter cleared by reset, so execution starts at zero
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			pc <= CBSC_PC_RESET;
		end else begin
			pc <= next_pc;
		end
	end

	// Phase decodes
	wire holding_w = (state == CBSC_HOLD);
	wire in_t1_w = (state == CBSC_T1) && sync_out;
	wire in_t2_w = (state == CBSC_T2);
	wire in_t3_w = (state == CBSC_T3);
	wire rd_cyc_w = status_latch[CBSC_ST_WO_N];
	wire data_phase_w = in_t2_w || in_t3_w;

	// Processor control outputs
	assign bus_hold_ack_out = holding_w;
	assign read_data_accept_out = data_phase_w && rd_cyc_w;
	assign write_strobe_n_out = !(in_t3_w && !rd_cyc_w);

	// Decoded strobes: status latch with three control outputs
	// Reads open with the accept window so chip selects settle early
	assign mem_read_n_out = !(status_latch[CBSC_ST_MEMR] &&
		read_data_accept_out);
	assign io_read_n_out = !(status_latch[CBSC_ST_INP] &&
		read_data_accept_out);
	assign irq_acknowledge_n_out = !(status_latch[CBSC_ST_IRQ_ACKNOWLEDGE] &&
		read_data_accept_out);
	assign mem_write_n_out = !(!status_latch[CBSC_ST_OUT] &&
		!write_strobe_n_out);
	assign io_write_n_out = !(status_latch[CBSC_ST_OUT] &&
		!write_strobe_n_out);

	// All controller outputs float in hold
	// Floating every strobe lets the video master own memory control
	assign ctrl_oe_n_out = holding_w;
	assign addr_oe_n_out = holding_w;
	assign addr_out = cyc_addr;

	// Bus drive: status in first state, write data later
	assign bidir_data_bus_oe_n_out = holding_w ||
		!(in_t1_w || (data_phase_w && !rd_cyc_w));
	assign bidir_data_bus_out = in_t1_w ? status : cyc_wdata;

	// Write data copied to the one-way bus in the write state; read data
	// taken on the state's last clock, when it has had longest to settle
	wire out_load_w = in_t3_w && !rd_cyc_w;
	wire rd_take_w = tick && in_t3_w && rd_cyc_w;
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			out_data_bus_out <= 8'h00;
			rdata_out <= 8'h00;
		end else begin
			if (out_load_w) begin
				out_data_bus_out <= cyc_wdata;
			end
			if (rd_take_w) begin
				rdata_out <= bidir_data_bus_in;
			end
		end
	end

	// One-cycle done pulse at end of a non-vector cycle
	// Vector cycles end silently; the waiting request goes next
	assign req_done_out = tick && in_t3_w && !vector_cycle;
endmodule
`default_nettype wire

// ==== hdl/cbsc_frame_irq.sv ====
// Frame-rate interrupt pulse generator, 50 or 60 per second
`timescale 1ns/100ps
`default_nettype none
module cbsc_frame_irq #(
	parameter int FRAME_CYC_50 = cbsc_pkg::CBSC_FRAME_CYC_50,
	parameter int FRAME_CYC_60 = cbsc_pkg::CBSC_FRAME_CYC_60
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic rate_50hz_in,
	output logic frame_irq_out
);
	import cbsc_pkg::*;
	logic [23:0] cnt;
	wire [23:0] top_w = rate_50hz_in ? 24'(FRAME_CYC_50 - 1) :
		24'(FRAME_CYC_60 - 1);
	wire wrap_w = (cnt >= top_w);
	// One pulse per frame
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			cnt <= 24'h000000;
			frame_irq_out <= 1'b0;
		end else begin
			cnt <= wrap_w ? 24'h000000 : cnt + 24'h000001;
			frame_irq_out <= wrap_w;
		end
	end
endmodule
`default_nettype wire

// ==== hdl/cbsc_pkg.sv ====
// Package with constants and types of the processor bus system controller
package cbsc_pkg;
	localparam int CBSC_XTAL_KHZ = 24883;
	localparam int CBSC_DIV = 9;
	localparam logic [3:0] CBSC_DIV_LAST = 4'h8;
	localparam logic [3:0] CBSC_PH1_END = 4'h2;
	localparam logic [3:0] CBSC_STB_TICK = 4'h8;
	localparam logic [15:0] CBSC_PC_RESET = 16'h0000;
	localparam int CBSC_FRAME_HZ_50 = 50;
	localparam int CBSC_FRAME_HZ_60 = 60;
	localparam int CBSC_CLK_HZ = 100000000;
	localparam int CBSC_FRAME_CYC_50 = CBSC_CLK_HZ / CBSC_FRAME_HZ_50;
	localparam int CBSC_FRAME_CYC_60 = CBSC_CLK_HZ / CBSC_FRAME_HZ_60;
	// Status byte flag positions
	localparam int CBSC_ST_IRQ_ACKNOWLEDGE = 0;
	localparam int CBSC_ST_WO_N = 1;
	localparam int CBSC_ST_OUT = 4;
	localparam int CBSC_ST_M1 = 5;
	localparam int CBSC_ST_INP = 6;
	localparam int CBSC_ST_MEMR = 7;
	typedef enum logic [1:0] {CBSC_T1, CBSC_T2, CBSC_T3, CBSC_HOLD} cbsc_state_t;
endpackage

// ==== tb/cbsc_core_assertions.sv ====
// Port checks for the processor bus core
`timescale 1ns/100ps
`default_nettype none
module cbsc_core_checker (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic hold_request_in,
	input wire logic bus_hold_ack_out,
	input wire logic ctrl_oe_n_out,
	input wire logic addr_oe_n_out,
	input wire logic bidir_data_bus_oe_n_out,
	input wire logic [7:0] bidir_data_bus_out,
	input wire logic sync_out,
	input wire logic status_latch_strobe_out,
	input wire logic write_strobe_n_out,
	input wire logic read_data_accept_out,
	input wire logic phase1_out,
	input wire logic phase2_out,
	input wire logic serial_clk_out,
	input wire logic frame_irq_out,
	input wire logic reset_out,
	input wire logic reset_n_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	// Strobe stays quiet for the rest of the divider count
	sequence s_quiet;
		!status_latch_strobe_out [*8];
	endsequence
	// Two clocks of write strobe in a row
	sequence s_wr_run;
		!write_strobe_n_out ##1 !write_strobe_n_out;
	endsequence
	chk_strobe_gap: assert property (
		status_latch_strobe_out |=> s_quiet) else $error("strobe repeats");
	chk_strobe_sync: assert property (
		status_latch_strobe_out |-> sync_out) else $error("strobe w/o sync");
	chk_phase_pair: assert property (
		!(phase1_out && phase2_out) && serial_clk_out == phase2_out)
		else $error("phase overlap");
	chk_frame_pulse: assert property (
		frame_irq_out |=> !frame_irq_out) else $error("frame pulse long");
	chk_write_stable: assert property (
		s_wr_run |-> $stable(bidir_data_bus_out) && !bidir_data_bus_oe_n_out)
		else $error("write data moved");
	chk_read_float: assert property (
		read_data_accept_out |-> bidir_data_bus_oe_n_out)
		else $error("bus driven in read");
	chk_hold_float: assert property (
		bus_hold_ack_out |-> ctrl_oe_n_out && addr_oe_n_out &&
		bidir_data_bus_oe_n_out) else $error("bus not floated");
	chk_hold_cause: assert property (
		$rose(bus_hold_ack_out) |-> $past(hold_request_in))
		else $error("hold ack unasked");
	chk_hold_leave: assert property (
		$fell(hold_request_in) |-> ##[0:20] !bus_hold_ack_out)
		else $error("hold ack stuck");
	chk_reset_pair: assert property (
		reset_n_out == !reset_out && !reset_out) else $error("reset pair");
endmodule
bind cbsc_core cbsc_core_checker cbsc_core_checker_i (.*);
`default_nettype wire

// ==== tb/cbsc_core_test.sv ====
// Self-checking bench for the processor bus core
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
	$display("Error %0t %h %h", $time, a, b); end end
module cbsc_core_test;
	import cbsc_pkg::*;
	logic clk_sys_in = 0, rst_in = 1, req_valid_in = 0, req_write_in = 0;
	logic req_io_in = 0, hold_request_in = 0, ready_in = 1;
	logic irq_request_line_in = 0, rate_50hz_in = 0, hs;
	logic [15:0] req_addr_in = 0, pc_out, addr_out;
	logic [7:0] req_wdata_in = 0, rdata_out, bidir_data_bus_in;
	logic [7:0] bidir_data_bus_out, out_data_bus_out, m [int], d [8];
	logic req_done_out, bidir_data_bus_oe_n_out, addr_oe_n_out;
	logic mem_read_n_out, mem_write_n_out, io_read_n_out, io_write_n_out;
	logic irq_acknowledge_n_out, ctrl_oe_n_out, bus_hold_ack_out, sync_out;
	logic read_data_accept_out, write_strobe_n_out, phase1_out, phase2_out;
	logic serial_clk_out, status_latch_strobe_out, frame_irq_out;
	logic reset_out, reset_n_out, io [8];
	logic [7:0] a [8];
	int failures = 0, comparisons = 0;
	localparam int FRAME_50 = 100, FRAME_60 = 84;
	cbsc_core #(.FRAME_CYC_50(FRAME_50), .FRAME_CYC_60(FRAME_60))
		cbsc_core_i (.*);
	cbsc_partner #(.VEC(8'h38)) cbsc_partner_i (.*);
	always #5 clk_sys_in = ~clk_sys_in;
	task automatic test_done;
		if (failures == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// One bus cycle, held until done; checked against the bench's map
	task automatic op(input logic w, s, input logic [7:0] ad, dt);
		int n = 0;
		hs = 0;
		@(negedge clk_sys_in);
		{req_valid_in, req_write_in, req_io_in} = {1'b1, w, s};
		req_addr_in = {8'h20, ad};
		req_wdata_in = dt;
		// Done is combinational, so look at it half a clock from the edge
		do begin
			@(negedge clk_sys_in);
			hs |= bus_hold_ack_out === 1'b1;
			n++;
		end while (req_done_out !== 1'b1 && n < 400);
		`CHK(req_done_out, 1'b1)
		@(negedge clk_sys_in);
		req_valid_in = 0;
		`CHK(hs, 1'b0)
		if (w) begin
			m[{s, ad}] = dt;
			`CHK(out_data_bus_out, dt)
		end else
			`CHK(rdata_out, m[{s, ad}])
	endtask
	task automatic wt(input logic v);
		repeat (60) if (bus_hold_ack_out !== v) @(negedge clk_sys_in);
		`CHK(bus_hold_ack_out, v)
	endtask
	// Frame pulse spacing for one rate, measured over a whole frame
	task automatic fr(input logic r);
		int n = 0;
		rate_50hz_in = r;
		repeat (2) begin
			n = 0;
			do begin
				@(negedge clk_sys_in);
				n++;
			end while (frame_irq_out !== 1'b1 && n < 400);
		end
		`CHK(n, r ? FRAME_50 : FRAME_60)
	endtask
	initial begin
		void'($urandom(32'h7da11370));
		repeat (12) @(negedge clk_sys_in);
		`CHK({reset_out, reset_n_out}, 2'b10)
		rst_in = 0;
		`CHK(pc_out, CBSC_PC_RESET)
		fr(1'($urandom));
		fr(!rate_50hz_in);
		for (int i = 0; i < 8; i++) begin
			{io[i], a[i], d[i]} = {1'($urandom), 8'(i * 16 + $urandom % 16),
				8'($urandom)};
			op(1, io[i], a[i], d[i]);
		end
		for (int i = 0; i < 8; i++)
			op(0, io[i], a[i], 0);
		// Hold asked in mid-cycle; the cycle must finish first
		fork
			op(1, 0, 8'h11, 8'h5a);
			begin
				wait (sync_out === 1'b1);
				@(negedge clk_sys_in);
				hold_request_in = 1;
			end
		join
		wt(1);
		`CHK({ctrl_oe_n_out, addr_oe_n_out, bidir_data_bus_oe_n_out}, 3'h7)
		hold_request_in = 0;
		wt(0);
		// Wait states stretch the next read without changing its data
		fork
			op(0, 0, 8'h11, 0);
			begin
				ready_in = 0;
				repeat (30) @(negedge clk_sys_in);
				ready_in = 1;
			end
		join
		// A one-clock pulse on the line is enough to win the next cycle
		irq_request_line_in = 1;
		@(negedge clk_sys_in);
		irq_request_line_in = 0;
		repeat (200) if (pc_out !== 16'h0038) @(negedge clk_sys_in);
		`CHK(pc_out, 16'h0038)
		op(0, 0, 8'h11, 0);
		rst_in = 1;
		@(negedge clk_sys_in);
		rst_in = 0;
		`CHK(pc_out, CBSC_PC_RESET)
		test_done;
	end
	initial begin
		repeat (30000) @(posedge clk_sys_in);
		failures++;
		test_done;
	end
endmodule
`default_nettype wire

// ==== tb/cbsc_partner.sv ====
// Memory, I/O and vector source on the far side of the bus
`timescale 1ns/100ps
`default_nettype none
module cbsc_partner #(
	parameter logic [7:0] VEC = 8'h38
) (
	input wire logic clk_sys_in,
	input wire logic [15:0] addr_out,
	input wire logic [7:0] bidir_data_bus_out,
	input wire logic bidir_data_bus_oe_n_out,
	input wire logic mem_read_n_out,
	input wire logic mem_write_n_out,
	input wire logic io_read_n_out,
	input wire logic io_write_n_out,
	input wire logic irq_acknowledge_n_out,
	input wire logic ctrl_oe_n_out,
	output logic [7:0] bidir_data_bus_in
);
	logic [7:0] mem [256];
	logic [7:0] io [256];
	// Floated strobes read as pulled high, as the DMA master leaves them
	wire on = !ctrl_oe_n_out;
	// Wire level: controller, then selected device, else pull-ups
	assign bidir_data_bus_in = !bidir_data_bus_oe_n_out ? bidir_data_bus_out
		: on && !irq_acknowledge_n_out ? VEC
		: on && !mem_read_n_out ? mem[addr_out[7:0]]
		: on && !io_read_n_out ? io[addr_out[7:0]] : 8'hff;
	// Writes land while the strobe is low
	always @(posedge clk_sys_in) begin
		if (on && !mem_write_n_out)
			mem[addr_out[7:0]] <= bidir_data_bus_out;
		if (on && !io_write_n_out)
			io[addr_out[7:0]] <= bidir_data_bus_out;
	end
endmodule
`default_nettype wire
